//--- rtl/motion_common_flags.v
`timescale 1ns/10ps
`default_nettype none
`include "motion_common_map.vh"

module motion_common_flags #(
  parameter AXES = 32,
  parameter SMALL_VARIANT = 0,
  parameter SMALL_AXES = 8,
  parameter CFG_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire run_switch,
  input wire test_mode_active_flag,
  input wire periph_write_req,
  output reg periph_write_accept,
  output reg periph_write_reject,
  input wire [AXES-1:0] servo_program_start_instr,
  output reg [AXES-1:0] axis_start_grant,
  output reg start_accept_on_error,
  output reg speed_from_first_point,
  input wire [AXES-1:0] positioning_done,
  input wire [AXES-1:0] midway_stop,
  input wire [AXES-1:0] speed_zero_stop,
  input wire [AXES-1:0] jog_forward_command,
  input wire [AXES-1:0] jog_reverse_command,
  input wire [AXES-1:0] handwheel_enable_flags,
  input wire [AXES-1:0] current_value_change_instr,
  input wire [AXES-1:0] current_value_change_done,
  output reg [AXES-1:0] start_accepted_flags,
  output wire motion_permit,
  output reg sequence_ready_flag,
  output reg motion_ready_complete_flag,
  output reg mcode_clear,
  output reg auto_start_programs,
  output reg ready_start_error,
  output reg [AXES-1:0] decel_stop_axes,
  output reg program_halt,
  output reg [31:0] real_output_points,
  input wire link_comm_error,
  input wire link_comm_ok,
  output reg link_comm_error_flag,
  output reg error_history_erase,
  input wire program_error_event,
  output reg program_error_detect_flag,
  input wire [CFG_W-1:0] config_setting,
  input wire [CFG_W-1:0] installed_modules,
  output reg config_error_flag,
  output wire error_led,
  input wire slot_module_abnormal,
  output reg slot_fault_flag,
  input wire [AXES-1:0] servo_error,
  output wire [AXES-1:0] servo_enable,
  output reg servo_on_acknowledge_flag,
  output reg [AXES-1:0] simjog_start_axes,
  output reg [AXES-1:0] simjog_stop_axes
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mask of axes that exist in this variant
  function [AXES-1:0] axis_mask;
    input dummy;
    integer i;
    begin
      for (i = 0; i < AXES; i = i + 1) begin
        axis_mask[i] = (SMALL_VARIANT == 0) || (i < SMALL_AXES);
      end
    end
  endfunction

  function addr_hit;
    input [3:0] a;
    input [3:0] want;
    begin
      addr_hit = (a == want);
    end
  endfunction

  wire [AXES-1:0] valid_axes;
  assign valid_axes = axis_mask(1'b0);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages per pin; only the second stage is read by logic
  reg run_meta, run_sync;
  reg slot_meta, slot_sync;
  reg [CFG_W-1:0] cfg_meta, cfg_sync;
  reg [CFG_W-1:0] inst_meta, inst_sync;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_meta <= 1'b0;
      run_sync <= 1'b0;
      slot_meta <= 1'b0;
      slot_sync <= 1'b0;
      cfg_meta <= {CFG_W{1'b0}};
      cfg_sync <= {CFG_W{1'b0}};
      inst_meta <= {CFG_W{1'b0}};
      inst_sync <= {CFG_W{1'b0}};
    end else begin
      run_meta <= run_switch;
      run_sync <= run_meta;
      slot_meta <= slot_module_abnormal;
      slot_sync <= slot_meta;
      cfg_meta <= config_setting;
      cfg_sync <= cfg_meta;
      inst_meta <= installed_modules;
      inst_sync <= inst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  reg [31:0] ctrl_reg;
  reg [31:0] ready_set_reg;
  reg [31:0] simjog_axes_reg;
  reg [AXES-1:0] servo_off_reg;
  reg hist_req_reg;

  wire wr_ctrl, wr_ready, wr_acc, wr_perr, wr_out;
  assign wr_ctrl = reg_wr && addr_hit(reg_addr, `ADDR_CTRL);
  assign wr_ready = reg_wr && addr_hit(reg_addr, `ADDR_READY_SET);
  assign wr_acc = reg_wr && addr_hit(reg_addr, `ADDR_START_ACC);
  assign wr_perr = reg_wr && addr_hit(reg_addr, `ADDR_PERR_CLR);
  assign wr_out = reg_wr && addr_hit(reg_addr, `ADDR_REAL_OUT);

  // A clear request lasts one cycle; a fresh write beats the drop
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= `CTRL_RESET;
      ready_set_reg <= `WORD_RESET;
      simjog_axes_reg <= `WORD_RESET;
      servo_off_reg <= {AXES{1'b0}};
      hist_req_reg <= 1'b0;
      error_history_erase <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata;
      end
      if (wr_ready) begin
        ready_set_reg <= reg_wdata;
      end
      if (reg_wr && addr_hit(reg_addr, `ADDR_SIMJOG_AXES)) begin
        simjog_axes_reg <= reg_wdata;
      end
      if (reg_wr && addr_hit(reg_addr, `ADDR_SERVO_OFF)) begin
        servo_off_reg <= reg_wdata[AXES-1:0];
      end
      error_history_erase <= hist_req_reg;
      hist_req_reg <= wr_ctrl && reg_wdata[`CTRL_HIST_CLR];
    end
  end

  // ----------------------------------------------------------------
  // Sequence ready flag
  // ----------------------------------------------------------------
  reg ready_bit_d;
  reg seq_ready_next;
  wire alt_mode;
  assign alt_mode = ctrl_reg[`CTRL_READY_MODE];

  // Default mode tracks the switch, so a release at run also sets it
  always @* begin
    seq_ready_next = sequence_ready_flag;
    if (!alt_mode) begin
      seq_ready_next = run_sync;
    end else if (!run_sync) begin
      seq_ready_next = 1'b0;
    end else if (ready_set_reg[0] && !ready_bit_d) begin
      seq_ready_next = 1'b1;
    end else if (!ready_set_reg[0] && ready_bit_d) begin
      seq_ready_next = 1'b0;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sequence_ready_flag <= 1'b0;
      ready_bit_d <= 1'b0;
    end else begin
      sequence_ready_flag <= seq_ready_next;
      ready_bit_d <= ready_set_reg[0];
    end
  end

  // ----------------------------------------------------------------
  // Ready edge processing
  // ----------------------------------------------------------------
  reg seq_d;
  reg rise_pending_reg;
  wire seq_rise, seq_fall, do_rise;
  assign seq_rise = sequence_ready_flag && !seq_d;
  assign seq_fall = !sequence_ready_flag && seq_d;
  // Deferred rise fires once test mode ends with ready still high
  assign do_rise = (seq_rise || rise_pending_reg) && sequence_ready_flag &&
                   !test_mode_active_flag;

  // Motion is allowed only when ready, not testing, config sane
  assign motion_permit = sequence_ready_flag && !test_mode_active_flag &&
                         !config_error_flag;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_d <= 1'b0;
      rise_pending_reg <= 1'b0;
      motion_ready_complete_flag <= 1'b0;
      mcode_clear <= 1'b0;
      auto_start_programs <= 1'b0;
      ready_start_error <= 1'b0;
      decel_stop_axes <= {AXES{1'b0}};
      program_halt <= 1'b0;
    end else begin
      seq_d <= sequence_ready_flag;
      mcode_clear <= 1'b0;
      auto_start_programs <= 1'b0;
      ready_start_error <= 1'b0;
      decel_stop_axes <= {AXES{1'b0}};
      program_halt <= 1'b0;
      if (seq_rise && test_mode_active_flag) begin
        rise_pending_reg <= 1'b1;
      end else if (do_rise || seq_fall) begin
        rise_pending_reg <= 1'b0;
      end
      if (do_rise) begin
        if (|start_accepted_flags) begin
          ready_start_error <= 1'b1;
        end else begin
          mcode_clear <= 1'b1;
          motion_ready_complete_flag <= 1'b1;
          auto_start_programs <= 1'b1;
        end
      end
      if (seq_fall) begin
        motion_ready_complete_flag <= 1'b0;
        decel_stop_axes <= start_accepted_flags;
        program_halt <= 1'b1;
      end
    end
  end

  // Outputs drop on the ready fall; the fall wins over a write
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      real_output_points <= `WORD_RESET;
    end else if (seq_fall) begin
      real_output_points <= `WORD_RESET;
    end else if (wr_out) begin
      real_output_points <= reg_wdata;
    end
  end

  // Peripheral parameter writes only while not ready
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_write_accept <= 1'b0;
      periph_write_reject <= 1'b0;
    end else begin
      periph_write_accept <= periph_write_req && !sequence_ready_flag;
      periph_write_reject <= periph_write_req && sequence_ready_flag;
    end
  end

  // ----------------------------------------------------------------
  // Start accepted flags and starts
  // ----------------------------------------------------------------
  reg simjog_d;
  reg [AXES-1:0] simjog_active_reg;
  reg [AXES-1:0] hold_d;
  reg [AXES-1:0] acc_next;
  wire [AXES-1:0] start_req, start_ok, start_refused, hold, clear_evt;

  assign start_req = servo_program_start_instr & valid_axes & {AXES{motion_permit}};
  // A flag already set (forced by software) refuses the start
  assign start_ok = start_req & ~start_accepted_flags;
  assign start_refused = start_req & start_accepted_flags;
  assign hold = (jog_forward_command | jog_reverse_command |
                 handwheel_enable_flags | simjog_active_reg) &
                {AXES{motion_permit}};
  // Zero-speed stop leaves the flag up
  assign clear_evt = positioning_done | (midway_stop & ~speed_zero_stop) |
                     current_value_change_done | (hold_d & ~hold);

  // Set wins over clear and over a software write
  always @* begin
    acc_next = wr_acc ? reg_wdata[AXES-1:0] : start_accepted_flags;
    acc_next = acc_next & ~clear_evt;
    acc_next = acc_next | start_ok | hold |
               (current_value_change_instr & {AXES{motion_permit}});
    acc_next = acc_next & valid_axes;
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_accepted_flags <= {AXES{1'b0}};
      hold_d <= {AXES{1'b0}};
      axis_start_grant <= {AXES{1'b0}};
      start_accept_on_error <= 1'b0;
      speed_from_first_point <= 1'b0;
    end else begin
      start_accepted_flags <= acc_next;
      hold_d <= hold;
      axis_start_grant <= start_ok;
      start_accept_on_error <= |start_refused;
      if (|start_ok) begin
        speed_from_first_point <= ctrl_reg[`CTRL_SPEED_SW];
      end
    end
  end

  // ----------------------------------------------------------------
  // Simultaneous jog
  // ----------------------------------------------------------------
  wire simjog_cmd;
  assign simjog_cmd = ctrl_reg[`CTRL_SIMJOG];

  // Axis selection is latched at the command edge
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      simjog_d <= 1'b0;
      simjog_active_reg <= {AXES{1'b0}};
      simjog_start_axes <= {AXES{1'b0}};
      simjog_stop_axes <= {AXES{1'b0}};
    end else begin
      simjog_d <= simjog_cmd;
      simjog_start_axes <= {AXES{1'b0}};
      simjog_stop_axes <= {AXES{1'b0}};
      if (simjog_cmd && !simjog_d && motion_permit) begin
        simjog_active_reg <= simjog_axes_reg[AXES-1:0] & valid_axes;
        simjog_start_axes <= simjog_axes_reg[AXES-1:0] & valid_axes;
      end else if (!simjog_cmd && simjog_d) begin
        simjog_active_reg <= {AXES{1'b0}};
        simjog_stop_axes <= simjog_active_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error and health flags
  // ----------------------------------------------------------------
  reg [1:0] cfg_wait_reg;
  reg cfg_done_reg;

  // Program error: set wins over the software clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      program_error_detect_flag <= 1'b0;
      link_comm_error_flag <= 1'b0;
      slot_fault_flag <= 1'b0;
    end else begin
      if (program_error_event) begin
        program_error_detect_flag <= 1'b1;
      end else if (wr_perr && reg_wdata[0]) begin
        program_error_detect_flag <= 1'b0;
      end
      if (link_comm_error) begin
        link_comm_error_flag <= 1'b1;
      end else if (link_comm_ok) begin
        link_comm_error_flag <= 1'b0;
      end
      slot_fault_flag <= slot_sync;
    end
  end

  // Check waits for the synchronisers to fill; only reset reruns it
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_wait_reg <= 2'h0;
      cfg_done_reg <= 1'b0;
      config_error_flag <= 1'b0;
    end else if (!cfg_done_reg) begin
      if (cfg_wait_reg == `CFG_CHECK_DELAY) begin
        cfg_done_reg <= 1'b1;
        config_error_flag <= (cfg_sync != inst_sync);
      end else begin
        cfg_wait_reg <= cfg_wait_reg + 2'h1;
      end
    end
  end

  assign error_led = config_error_flag;

  // ----------------------------------------------------------------
  // Servo enable
  // ----------------------------------------------------------------
  // Nothing here clears the all-on command on a CPU stop
  assign servo_enable = {AXES{ctrl_reg[`CTRL_SERVO_ON]}} & ~servo_off_reg &
                        ~servo_error & valid_axes;

  // Acknowledge reflects acceptance only, not axis readiness
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      servo_on_acknowledge_flag <= 1'b0;
    end else begin
      servo_on_acknowledge_flag <= ctrl_reg[`CTRL_SERVO_ON];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0000_0000;
    case (reg_addr)
      `ADDR_CTRL: begin
        rd_word = {ctrl_reg[31:5], hist_req_reg, ctrl_reg[3:0]};
      end
      `ADDR_READY_SET: rd_word = ready_set_reg;
      `ADDR_SIMJOG_AXES: rd_word = simjog_axes_reg;
      `ADDR_SERVO_OFF: rd_word[AXES-1:0] = servo_off_reg;
      `ADDR_START_ACC: rd_word[AXES-1:0] = start_accepted_flags;
      `ADDR_STATUS: begin
        rd_word[`ST_SEQ_READY] = sequence_ready_flag;
        rd_word[`ST_MRC] = motion_ready_complete_flag;
        rd_word[`ST_LINK_ERR] = link_comm_error_flag;
        rd_word[`ST_PROG_ERR] = program_error_detect_flag;
        rd_word[`ST_CFG_ERR] = config_error_flag;
        rd_word[`ST_SLOT_FAULT] = slot_fault_flag;
        rd_word[`ST_SERVO_ACK] = servo_on_acknowledge_flag;
        rd_word[`ST_TEST_MODE] = test_mode_active_flag;
        rd_word[`ST_HIST_CLR] = hist_req_reg;
      end
      `ADDR_REAL_OUT: rd_word = real_output_points;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_word;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // motion_common_flags
`default_nettype wire

//--- rtl/motion_common_map.vh
`ifndef MOTION_COMMON_MAP_VH
`define MOTION_COMMON_MAP_VH
// Register word addresses
`define ADDR_CTRL 4'h0
`define ADDR_READY_SET 4'h1
`define ADDR_SIMJOG_AXES 4'h2
`define ADDR_SERVO_OFF 4'h3
`define ADDR_START_ACC 4'h4
`define ADDR_STATUS 4'h5
`define ADDR_PERR_CLR 4'h6
`define ADDR_REAL_OUT 4'h7
// Control register fields
`define CTRL_READY_MODE 0
`define CTRL_SERVO_ON 1
`define CTRL_SPEED_SW 2
`define CTRL_SIMJOG 3
`define CTRL_HIST_CLR 4
// Status register fields
`define ST_SEQ_READY 0
`define ST_MRC 1
`define ST_LINK_ERR 2
`define ST_PROG_ERR 3
`define ST_CFG_ERR 4
`define ST_SLOT_FAULT 5
`define ST_SERVO_ACK 6
`define ST_TEST_MODE 7
`define ST_HIST_CLR 8
// Reset values
`define CTRL_RESET 32'h0000_0000
`define WORD_RESET 32'h0000_0000
// Cycles after reset release before the configuration check
`define CFG_CHECK_DELAY 2'h3
`endif

//--- tb/flags_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "motion_common_map.vh"

// ----------------------------------------
// Port-level checks of the common flag block
// ----------------------------------------
module flags_monitor #(
  parameter AXES = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic test_mode_active_flag,
  input wire logic periph_write_req,
  input wire logic periph_write_accept,
  input wire logic periph_write_reject,
  input wire logic [AXES-1:0] axis_start_grant,
  input wire logic [AXES-1:0] start_accepted_flags,
  input wire logic motion_permit,
  input wire logic sequence_ready_flag,
  input wire logic motion_ready_complete_flag,
  input wire logic auto_start_programs,
  input wire logic ready_start_error,
  input wire logic program_halt,
  input wire logic [31:0] real_output_points,
  input wire logic link_comm_error,
  input wire logic link_comm_error_flag,
  input wire logic program_error_detect_flag,
  input wire logic config_error_flag,
  input wire logic error_led,
  input wire logic [AXES-1:0] servo_error,
  input wire logic [AXES-1:0] servo_enable,
  input wire logic servo_on_acknowledge_flag
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_PERMIT: assert property (
    |axis_start_grant |-> $past(motion_permit && sequence_ready_flag && !test_mode_active_flag))
    else $error("start granted while not ready or in test");
  AST_PERIPH: assert property (
    periph_write_req |=> periph_write_accept != $past(sequence_ready_flag)
      && periph_write_reject == $past(sequence_ready_flag))
    else $error("peripheral write verdict wrong");
  AST_RISE: assert property (
    $rose(sequence_ready_flag) && !test_mode_active_flag && !config_error_flag
      && start_accepted_flags == '0
      |-> ##[1:2] motion_ready_complete_flag && auto_start_programs)
    else $error("ready rise not processed");
  AST_RISE_ERR: assert property (
    $rose(sequence_ready_flag) && !test_mode_active_flag && start_accepted_flags != '0
      |-> ##[1:2] ready_start_error)
    else $error("start at ready rise not flagged");
  AST_FALL: assert property (
    $fell(sequence_ready_flag)
      |-> ##[1:2] !motion_ready_complete_flag && program_halt && real_output_points == '0)
    else $error("ready fall not processed");
  AST_GRANT: assert property (
    (axis_start_grant & ~start_accepted_flags) == '0)
    else $error("grant without accepted flag");
  AST_LINK: assert property (
    link_comm_error |=> link_comm_error_flag)
    else $error("link error not flagged");
  AST_PROG: assert property (
    $fell(program_error_detect_flag)
      |-> $past(reg_wr && reg_addr == `ADDR_PERR_CLR && reg_wdata[0]))
    else $error("program error self-cleared");
  AST_LED: assert property (
    config_error_flag |=> axis_start_grant == '0 && error_led)
    else $error("start granted under config error");
  AST_SERVO: assert property (
    (servo_enable & servo_error) == '0)
    else $error("servo enabled on axis in error");
  AST_ACK: assert property (
    reg_wr && reg_addr == `ADDR_CTRL && reg_wdata[1] |-> ##[1:3] servo_on_acknowledge_flag)
    else $error("servo-on not acknowledged");
endmodule // flags_monitor

bind motion_common_flags flags_monitor #(.AXES(AXES)) mon (.*);

`default_nettype wire

//--- tb/axis_partner.sv
`timescale 1ns/10ps
`default_nettype none

// Motion program side: finishes axis 0 positioning after a delay
module axis_partner #(
  parameter FAST = 3,
  parameter SLOW = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic [31:0] axis_start_grant,
  output logic [31:0] positioning_done
);
  int cnt;

  // Never touches the accepted flags, only reports completion
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 0;
      positioning_done <= '0;
    end else begin
      positioning_done <= '0;
      if (axis_start_grant[0])
        cnt <= slow ? SLOW : FAST;
      else if (cnt != 0) begin
        cnt <= cnt - 1;
        positioning_done[0] <= (cnt == 1);
      end
    end
  end
endmodule // axis_partner

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "motion_common_map.vh"

module tb;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, run_switch = 0, slow = 0;
  logic test_mode_active_flag = 0, periph_write_req = 0, link_comm_error = 0;
  logic link_comm_ok = 0, program_error_event = 0, slot_module_abnormal = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] config_setting = 16'h0012, installed_modules = 16'h0012;
  logic [31:0] reg_wdata = '0, servo_program_start_instr = '0, midway_stop = '0;
  logic [31:0] speed_zero_stop = '0, jog_forward_command = '0, jog_reverse_command = '0;
  logic [31:0] handwheel_enable_flags = '0, current_value_change_instr = '0;
  logic [31:0] current_value_change_done = '0, servo_error = '0, sj = '0, sp = '0, sd = '0, v;
  logic [31:0] reg_rdata, real_output_points, positioning_done, axis_start_grant;
  logic [31:0] start_accepted_flags, decel_stop_axes, simjog_start_axes;
  logic [31:0] simjog_stop_axes, servo_enable;
  logic periph_write_accept, periph_write_reject, start_accept_on_error;
  logic speed_from_first_point, motion_permit, sequence_ready_flag, mcode_clear;
  logic motion_ready_complete_flag, auto_start_programs, ready_start_error;
  logic program_halt, link_comm_error_flag, error_history_erase, error_led;
  logic program_error_detect_flag, config_error_flag, slot_fault_flag;
  logic servo_on_acknowledge_flag;
  int mismatches = 0, n_compared = 0;
  int pc[5] = '{default: 0};
  typedef struct {logic [31:0] ctrl, off, err, exp;} row_t;
  row_t rows[4] = '{'{32'h0000_0002, '0, '0, 32'hffff_ffff},
    '{32'h0000_0002, 32'h0000_0001, 32'h0000_0002, 32'hffff_fffc},
    '{32'h0000_0002, 32'hffff_0000, '0, 32'h0000_ffff}, '{'0, '0, '0, '0}};

  motion_common_flags uut (.*);

  axis_partner partner (.*);

  // 10 MHz clock
  always #50 clk = ~clk;

  // One-cycle pulses are tallied, not polled
  always @(posedge clk) begin
    pc[0] += error_history_erase;
    pc[1] += ready_start_error;
    pc[2] += start_accept_on_error;
    pc[3] += program_halt;
    pc[4] += mcode_clear;
    sd <= sd | decel_stop_axes;
    sj <= sj | simjog_start_axes;
    sp <= sp | simjog_stop_axes;
  end

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task chk(input logic [63:0] s, e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task sn(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    sn(1);
    v = reg_rdata;
  endtask
  task pw(input logic [1:0] e);
    @(posedge clk) periph_write_req <= 1'b1;
    @(posedge clk) periph_write_req <= 1'b0;
    sn(1);
    chk({periph_write_accept, periph_write_reject}, e);
  endtask
  task st(input logic [31:0] m);
    @(posedge clk) servo_program_start_instr <= m;
    @(posedge clk) servo_program_start_instr <= '0;
    sn(1);
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    complete_run;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    chk({sequence_ready_flag, motion_ready_complete_flag, start_accepted_flags}, '0);
    sys_rst <= 1'b0;
    sn(8);
    chk(config_error_flag, 1'b0);
    pw(2'b10);
    foreach (rows[i]) begin
      wr(`ADDR_CTRL, rows[i].ctrl);
      wr(`ADDR_SERVO_OFF, rows[i].off);
      @(posedge clk) servo_error <= rows[i].err;
      sn(2);
      chk(servo_enable, rows[i].exp);
      chk(servo_on_acknowledge_flag, rows[i].ctrl[1]);
    end
    // Forced flag makes the ready rise an error
    wr(`ADDR_START_ACC, 32'h0000_0001);
    @(posedge clk) run_switch <= 1'b1;
    sn(8);
    chk(pc[1], 1);
    chk(motion_ready_complete_flag, 1'b0);
    @(posedge clk) run_switch <= 1'b0;
    wr(`ADDR_START_ACC, '0);
    sn(6);
    // Rise during test mode waits for test to end
    @(posedge clk);
    run_switch <= 1'b1;
    test_mode_active_flag <= 1'b1;
    sn(8);
    chk({sequence_ready_flag, motion_ready_complete_flag, motion_permit}, 3'b100);
    @(posedge clk) test_mode_active_flag <= 1'b0;
    sn(4);
    chk({sequence_ready_flag, motion_ready_complete_flag, motion_permit}, 3'b111);
    chk(pc[4], 1);
    pw(2'b01);
    for (int i = 0; i < 2; i++) begin
      wr(`ADDR_CTRL, i << 2);
      slow <= i[0];
      st(32'h0000_0001);
      chk(start_accepted_flags, 32'h0000_0001);
      chk(speed_from_first_point, i[0]);
      sn(20);
      chk(start_accepted_flags, '0);
    end
    st(32'h0000_0002);
    @(posedge clk);
    midway_stop <= 32'h0000_0002;
    speed_zero_stop <= 32'h0000_0002;
    @(posedge clk);
    midway_stop <= '0;
    speed_zero_stop <= '0;
    sn(2);
    chk(start_accepted_flags, 32'h0000_0002);
    @(posedge clk) midway_stop <= 32'h0000_0002;
    @(posedge clk) midway_stop <= '0;
    sn(2);
    chk(start_accepted_flags, '0);
    wr(`ADDR_START_ACC, 32'h0000_0004);
    st(32'h0000_0004);
    sn(2);
    chk(pc[2], 1);
    wr(`ADDR_START_ACC, '0);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {handwheel_enable_flags[3], jog_reverse_command[3], jog_forward_command[3]} <= 3'b001 << k;
      sn(3);
      chk(start_accepted_flags, 32'h0000_0008);
      @(posedge clk);
      {handwheel_enable_flags[3], jog_reverse_command[3], jog_forward_command[3]} <= 3'b000;
      sn(3);
      chk(start_accepted_flags, '0);
    end
    @(posedge clk) current_value_change_instr <= 32'h0000_0020;
    @(posedge clk) current_value_change_instr <= '0;
    sn(1);
    chk(start_accepted_flags, 32'h0000_0020);
    @(posedge clk) current_value_change_done <= 32'h0000_0020;
    @(posedge clk) current_value_change_done <= '0;
    sn(1);
    chk(start_accepted_flags, '0);
    wr(`ADDR_SIMJOG_AXES, 32'h0000_0300);
    wr(`ADDR_CTRL, 32'h0000_0008);
    sn(3);
    chk(sj, 32'h0000_0300);
    wr(`ADDR_CTRL, '0);
    sn(3);
    chk(sp, 32'h0000_0300);
    // Ready fall must beat held outputs
    wr(`ADDR_REAL_OUT, 32'h0000_00a5);
    wr(`ADDR_START_ACC, 32'h0000_0010);
    @(posedge clk) run_switch <= 1'b0;
    sn(6);
    chk({sequence_ready_flag, motion_ready_complete_flag, real_output_points}, '0);
    chk(pc[3], 2);
    chk(sd, 32'h0000_0010);
    wr(`ADDR_CTRL, 32'h0000_0001);
    @(posedge clk) run_switch <= 1'b1;
    sn(6);
    chk(sequence_ready_flag, 1'b0);
    wr(`ADDR_READY_SET, 32'h0000_0001);
    sn(2);
    chk(sequence_ready_flag, 1'b1);
    wr(`ADDR_READY_SET, '0);
    sn(2);
    chk(sequence_ready_flag, 1'b0);
    @(posedge clk);
    link_comm_error <= 1'b1;
    program_error_event <= 1'b1;
    slot_module_abnormal <= 1'b1;
    @(posedge clk);
    link_comm_error <= 1'b0;
    program_error_event <= 1'b0;
    sn(4);
    chk({link_comm_error_flag, program_error_detect_flag, slot_fault_flag}, 3'h7);
    @(posedge clk);
    link_comm_ok <= 1'b1;
    slot_module_abnormal <= 1'b0;
    @(posedge clk) link_comm_ok <= 1'b0;
    sn(4);
    chk({link_comm_error_flag, program_error_detect_flag, slot_fault_flag}, 3'h2);
    wr(`ADDR_PERR_CLR, 32'h0000_0001);
    sn(1);
    chk(program_error_detect_flag, 1'b0);
    wr(`ADDR_CTRL, 32'h0000_0010);
    sn(3);
    chk(pc[0], 1);
    rd(`ADDR_CTRL);
    chk(v[4], 1'b0);
    rd(4'hf);
    chk(v, '0);
    // Second reset with a mismatched configuration
    @(posedge clk);
    config_setting <= 16'h0013;
    sys_rst <= 1'b1;
    @(posedge clk) sys_rst <= 1'b0;
    sn(8);
    chk({config_error_flag, error_led}, 2'b11);
    st(32'h0000_0001);
    chk(start_accepted_flags, '0);
    complete_run;
  end
endmodule // tb

`default_nettype wire
